// file: hdl/e1nb_fifo.sv
// Small flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps

module e1nb_fifo
#(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
)
(
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             reset_n,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  // DEPTH must be a power of two so the pointers wrap by themselves
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      count_r;
  logic [AW:0]      count_nxt;
  logic             not_full_r;
  wire              push;
  wire              pop;

  assign push      = in_valid & not_full_r;
  assign pop       = out_valid & out_ready;
  assign in_ready  = not_full_r;
  assign out_valid = (count_r != '0);
  assign out_data  = mem_r[rd_ptr_r];
  assign count_nxt = count_r + (AW+1)'(push) - (AW+1)'(pop);

  always_ff @(posedge sys_clk)
  begin
    if (push)
      mem_r[wr_ptr_r] <= in_data;
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_ptr_r   <= '0;
      rd_ptr_r   <= '0;
      count_r    <= '0;
      not_full_r <= 1'b1;
    end
    else
    begin
      wr_ptr_r   <= wr_ptr_r + AW'(push);
      rd_ptr_r   <= rd_ptr_r + AW'(pop);
      count_r    <= count_nxt;
      not_full_r <= (count_nxt != (AW+1)'(DEPTH));
    end
  end

endmodule : e1nb_fifo

// file: hdl/e1nb_inserter.sv
// E1 transmit national bit (Sa4..Sa8) codeword inserter
//
// How it works
// - Select codes 3..7 pick Sa4..Sa8; codes 0..2 are undefined.
// - Select and codeword registers stay in reset while T1 mode is chosen.
// - Codeword bits 1..4 go into odd frames 1..7 or 9..15 of TS0.
// - Codeword is latched once per submultiframe, at its start, and used for that one.
// - For Sa8 codeword bit order in the register is reversed.
// - Each codeword bit has its own enable; disabled bits pass through.
// - Enables count only while national insertion disable is zero.
`timescale 1ns/1ps
`include "e1nb_regs.svh"

module e1nb_inserter
#(
  parameter int FIFO_DEPTH = 8
)
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  // Avalon-MM register slave
  input  wire logic [11:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // Upstream transmit bit stream
  input  wire logic        up_valid,
  output logic             up_ready,
  input  wire logic        up_data,
  input  wire logic        up_ts0,
  input  wire logic [2:0]  up_bit_pos,
  input  wire logic [3:0]  up_frame,
  // Downstream transmit bit stream
  output logic             dn_valid,
  input  wire logic        dn_ready,
  output logic             dn_data,
  output logic             dn_ts0,
  output logic [2:0]       dn_bit_pos,
  output logic [3:0]       dn_frame,
  output logic             dn_inserted
);

  localparam int WORD_W = 9;
  // Control reset word, taken apart bit by bit in the control register
  localparam logic [1:0] CTRL_RST = `E1NB_CTRL_RST;

  // --------------------------------------------------------------------------
  // Helper functions
  // --------------------------------------------------------------------------

  // True when a byte address hits the word of a register index
  function automatic logic addr_hit(input logic [11:0] addr,
                                    input logic [9:0]  idx);
    addr_hit = (addr[11:2] == idx) && (addr[1:0] == 2'b00);
  endfunction : addr_hit

  // Codeword bit n+1 of the stored byte; Sa8 keeps it in reversed order
  function automatic logic cw_data_bit(input logic [7:0] cw,
                                       input logic [1:0] n,
                                       input logic       rev);
    if (rev)
      cw_data_bit = cw[{1'b0, n}];
    else
      cw_data_bit = cw[{1'b0, ~n}];
  endfunction : cw_data_bit

  // Enable for codeword bit n+1 sits at bit 7-n in either order
  function automatic logic cw_enable_bit(input logic [7:0] cw,
                                         input logic [1:0] n);
    cw_enable_bit = cw[{1'b1, ~n}];
  endfunction : cw_enable_bit

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  e1nb_pkg::e1nb_bus_state_t bus_state_r;
  e1nb_pkg::e1nb_bus_state_t bus_state_nxt;

  logic [2:0]  codeword_select_r;
  logic [7:0]  codeword_r;
  logic [7:0]  codeword_latched_r;
  logic        submultiframe_r;
  logic        e1_mode_select_r;
  logic        national_insert_disable_r;
  logic        waitrequest_r;
  logic [31:0] readdata_r;

  // --------------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------------
  wire         bus_req;
  wire         bus_idle;
  wire         bus_ack;
  wire         wr_take;
  wire         hit_sel;
  wire         hit_cwd;
  wire         hit_ctrl;
  wire         hit_stat;
  wire         wr_low;
  wire [31:0]  rd_mux;

  assign bus_req  = avs_read | avs_write;
  assign bus_idle = (bus_state_r == e1nb_pkg::E1NB_BUS_IDLE);
  assign bus_ack  = (bus_state_r == e1nb_pkg::E1NB_BUS_ACK);
  // A write takes effect only on the edge that sees waitrequest low
  assign wr_take  = bus_ack & avs_write;
  assign wr_low   = wr_take & avs_byteenable[0];
  assign hit_sel  = addr_hit(avs_address, `E1NB_IDX_SEL);
  assign hit_cwd  = addr_hit(avs_address, `E1NB_IDX_CWD);
  assign hit_ctrl = addr_hit(avs_address, `E1NB_IDX_CTRL);
  assign hit_stat = addr_hit(avs_address, `E1NB_IDX_STAT);

  // Unmapped addresses read as zero and ignore writes
  assign rd_mux =
      hit_sel  ? {24'h000000, codeword_select_r, 5'h00} :
      hit_cwd  ? {24'h000000, codeword_r} :
      hit_ctrl ? {30'h0, national_insert_disable_r,
                  e1_mode_select_r} :
      hit_stat ? {16'h0000, codeword_latched_r, 7'h00, submultiframe_r} :
                 32'h00000000;

  always_comb
  begin
    bus_state_nxt = bus_state_r;
    case (bus_state_r)
      e1nb_pkg::E1NB_BUS_IDLE:
        if (bus_req)
          bus_state_nxt = e1nb_pkg::E1NB_BUS_ACK;
      e1nb_pkg::E1NB_BUS_ACK:
        bus_state_nxt = e1nb_pkg::E1NB_BUS_IDLE;
      default:
        bus_state_nxt = e1nb_pkg::E1NB_BUS_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      bus_state_r   <= e1nb_pkg::E1NB_BUS_IDLE;
      waitrequest_r <= 1'b1;
      readdata_r    <= 32'h00000000;
    end
    else
    begin
      bus_state_r   <= bus_state_nxt;
      waitrequest_r <= ~(bus_idle & bus_req);
      if (bus_idle & bus_req)
        readdata_r  <= rd_mux;
    end
  end

  assign avs_waitrequest = waitrequest_r;
  assign avs_readdata    = readdata_r;

  // --------------------------------------------------------------------------
  // Control register
  // --------------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      e1_mode_select_r          <= CTRL_RST[`E1NB_CTRL_E1];
      national_insert_disable_r <= CTRL_RST[`E1NB_CTRL_NATIONAL_INSERT_DISABLE];
    end
    else if (wr_low & hit_ctrl)
    begin
      e1_mode_select_r          <= avs_writedata[`E1NB_CTRL_E1];
      national_insert_disable_r <= avs_writedata[`E1NB_CTRL_NATIONAL_INSERT_DISABLE];
    end
  end

  // --------------------------------------------------------------------------
  // Codeword select and codeword registers
  // --------------------------------------------------------------------------
  // While the device runs in T1 mode both registers are forced to reset,
  // so a late switch to E1 always starts from a quiet codeword.
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      codeword_select_r <= `E1NB_SEL_RST;
      codeword_r        <= `E1NB_CWD_RST;
    end
    else if (!e1_mode_select_r)
    begin
      codeword_select_r <= `E1NB_SEL_RST;
      codeword_r        <= `E1NB_CWD_RST;
    end
    else
    begin
      if (wr_low & hit_sel)
        codeword_select_r <= avs_writedata[`E1NB_SEL_MSB:`E1NB_SEL_LSB];
      if (wr_low & hit_cwd)
        codeword_r        <= avs_writedata[7:0];
    end
  end

  // --------------------------------------------------------------------------
  // Stream buffer
  // --------------------------------------------------------------------------
  wire [WORD_W-1:0] fifo_in_word;
  wire [WORD_W-1:0] fifo_out_word;
  wire              fifo_out_valid;
  wire              fifo_out_ready;

  assign fifo_in_word = {up_frame, up_ts0, up_bit_pos, up_data};

  e1nb_fifo
  #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH)
  )
  u_fifo
  (
    .sys_clk   (sys_clk),
    .reset_n   (reset_n),
    .in_valid  (up_valid),
    .in_ready  (up_ready),
    .in_data   (fifo_in_word),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_word)
  );

  // --------------------------------------------------------------------------
  // Insertion decision
  // --------------------------------------------------------------------------
  wire [3:0] pop_frame;
  wire       pop_ts0;
  wire [2:0] pop_bit_pos;
  wire       pop_data;
  wire       pop_take;
  wire       smf_start;
  wire [1:0] cw_index;
  wire       select_defined;
  wire       select_sa8;
  wire       slot_hit;
  wire       bit_enabled;
  wire       insert_now;
  wire       insert_value;

  assign {pop_frame, pop_ts0, pop_bit_pos, pop_data} = fifo_out_word;

  // Output stage stalls when downstream holds off, which backs up the FIFO
  assign fifo_out_ready = ~dn_valid | dn_ready;
  assign pop_take       = fifo_out_valid & fifo_out_ready;

  // First bit of TS0 in frame 0 or 8 opens a submultiframe
  assign smf_start = pop_take & pop_ts0 & (pop_bit_pos == 3'h0)
                   & (pop_frame[2:0] == 3'h0);

  // Odd frames 1,3,5,7 carry codeword bits 1..4; same for 9..15
  assign cw_index       = pop_frame[2:1];
  assign select_defined = (codeword_select_r >= `E1NB_SEL_SA4);
  assign select_sa8     = (codeword_select_r == `E1NB_SEL_SA8);
  // Bit Sa(k) is TS0 bit k, i.e. position k-1, which equals the code
  assign slot_hit       = pop_ts0 & pop_frame[0]
                        & (pop_bit_pos == codeword_select_r);
  assign bit_enabled    = cw_enable_bit(codeword_latched_r,
                                        cw_index);
  assign insert_now     = select_defined & slot_hit & bit_enabled
                        & ~national_insert_disable_r;
  assign insert_value   = cw_data_bit(codeword_latched_r, cw_index,
                                      select_sa8);

  // --------------------------------------------------------------------------
  // Submultiframe latch
  // --------------------------------------------------------------------------
  // A write in E1 mode lands in the live register at any time; the stream only sees
  // it from the next submultiframe, so a codeword is never torn mid-way.
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      codeword_latched_r <= `E1NB_CWD_RST;
      submultiframe_r    <= 1'b0;
    end
    else if (!e1_mode_select_r)
    begin
      codeword_latched_r <= `E1NB_CWD_RST;
      submultiframe_r    <= 1'b0;
    end
    else if (smf_start)
    begin
      codeword_latched_r <= codeword_r;
      submultiframe_r    <= pop_frame[3];
    end
  end

  // --------------------------------------------------------------------------
  // Output stage
  // --------------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      dn_valid    <= 1'b0;
      dn_data     <= 1'b0;
      dn_ts0      <= 1'b0;
      dn_bit_pos  <= 3'h0;
      dn_frame    <= 4'h0;
      dn_inserted <= 1'b0;
    end
    else if (fifo_out_ready)
    begin
      dn_valid    <= fifo_out_valid;
      dn_data     <= insert_now ? insert_value : pop_data;
      dn_ts0      <= pop_ts0;
      dn_bit_pos  <= pop_bit_pos;
      dn_frame    <= pop_frame;
      dn_inserted <= fifo_out_valid & insert_now;
    end
  end

endmodule : e1nb_inserter

// file: hdl/e1nb_pkg.sv
// Types shared by the national bit inserter
package e1nb_pkg;

  // Avalon slave answer sequencer
  typedef enum logic [1:0]
  {
    E1NB_BUS_IDLE = 2'b01,
    E1NB_BUS_ACK  = 2'b10
  } e1nb_bus_state_t;

endpackage : e1nb_pkg

// file: hdl/e1nb_regs.svh
// Register map, field positions and reset values of the national bit inserter
`ifndef E1NB_REGS_SVH
`define E1NB_REGS_SVH

// --------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// --------------------------------------------------------------------------
`define E1NB_IDX_SEL      10'h086
`define E1NB_IDX_CWD      10'h087
`define E1NB_IDX_CTRL     10'h0a0
`define E1NB_IDX_STAT     10'h0a1

// --------------------------------------------------------------------------
// Field positions
// --------------------------------------------------------------------------
`define E1NB_SEL_LSB      5
`define E1NB_SEL_MSB      7
`define E1NB_CTRL_E1      0
`define E1NB_CTRL_NATIONAL_INSERT_DISABLE   1

// --------------------------------------------------------------------------
// Codeword select codes
// --------------------------------------------------------------------------
`define E1NB_SEL_SA4      3'h3
`define E1NB_SEL_SA8      3'h7

// --------------------------------------------------------------------------
// Reset values
// --------------------------------------------------------------------------
`define E1NB_SEL_RST      3'h0
`define E1NB_CWD_RST      8'h0f
`define E1NB_CTRL_RST     2'h0

`endif

// file: tb/e1nb_inserter_tb.sv
// Self-checking bench of the national bit inserter
`timescale 1ns/1ps
`include "e1nb_regs.svh"
module e1nb_inserter_tb;
  logic        sys_clk = 1'b0, reset_n = 1'b0;
  logic [11:0] avs_address = 12'h000;
  logic        avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic [3:0]  avs_byteenable = 4'hf;
  logic        up_valid = 1'b0, up_data = 1'b0, up_ts0 = 1'b0, up_ready;
  logic [2:0]  up_bit_pos = 3'h0, dn_bit_pos, sel = 3'h0;
  logic [3:0]  up_frame = 4'h0, dn_frame;
  logic        dn_valid, dn_ready, dn_data, dn_ts0, dn_inserted;
  logic        hold = 1'b0, dis = 1'b0;
  logic [7:0]  cw_act = 8'h00;
  logic [9:0]  exp_q[$];
  int          mismatches = 0, cmp_count = 0;
  wire  [9:0]  dn_word = {dn_ts0, dn_bit_pos, dn_frame, dn_data, dn_inserted};

  e1nb_inserter #(.FIFO_DEPTH(8)) i_e1nb_inserter (.*);
  e1nb_line_rx i_e1nb_line_rx (.*);

  initial forever #10 sys_clk = ~sys_clk;

  // --------------------------------------------------------------------
  // Checking and bus tasks
  // --------------------------------------------------------------------
  task automatic final_report();
    $display("checks %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : final_report

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic fail_wait();
    mismatches++;
    final_report();
  endtask : fail_wait

  task automatic bus(logic wr, logic [9:0] idx, logic [7:0] d,
                     output logic [7:0] q);
    int n;
    @(posedge sys_clk);
    avs_address <= {idx, 2'b00};
    avs_writedata <= {24'h0, d};
    avs_write <= wr;
    avs_read <= !wr;
    for (n = 0; n < 50 && avs_waitrequest !== 1'b0; n++)
      @(posedge sys_clk);
    q = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n == 50)
      fail_wait();
  endtask : bus

  task automatic wr(logic [9:0] idx, logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, idx, d, q);
  endtask : wr

  task automatic rd_chk(string s, logic [9:0] idx, logic [7:0] e);
    logic [7:0] q;
    bus(1'b0, idx, 8'h00, q);
    check(s, q, e);
  endtask : rd_chk

  function automatic logic [1:0] exp_out(logic [3:0] f, logic [2:0] p,
                                         logic t, logic d);
    int k;
    k = f[2:1];
    if (t && f[0] && !dis && sel >= 3'h3 && p == sel && cw_act[7-k])
      return {(sel == 3'h7) ? cw_act[k] : cw_act[3-k], 1'b1};
    return {d, 1'b0};
  endfunction : exp_out

  task automatic frames(int f0, int f1);
    logic [3:0] f;
    logic [2:0] p;
    logic       t;
    logic       d;
    int         n;
    @(posedge sys_clk);
    for (int i = f0; i <= f1; i++)
      for (int j = 0; j < 9; j++)
      begin
        f = 4'(i);
        t = (j < 8);
        p = t ? 3'(j) : sel;
        d = f[1] ^ p[0];
        exp_q.push_back({t, p, f, exp_out(f, p, t, d)});
        up_valid <= 1'b1;
        {up_frame, up_bit_pos, up_ts0, up_data} <= {f, p, t, d};
        for (n = 0; n < 50; n++)
        begin
          @(posedge sys_clk);
          if (up_ready === 1'b1)
            break;
        end
        if (n == 50)
          fail_wait();
      end
    up_valid <= 1'b0;
  endtask : frames

  task automatic drain();
    for (int n = 0; exp_q.size() != 0; n++)
    begin
      if (n == 500)
        fail_wait();
      @(posedge sys_clk);
    end
  endtask : drain

  always @(posedge sys_clk)
    if (dn_valid === 1'b1 && dn_ready === 1'b1)
      check("dn word", dn_word, exp_q.pop_front());

  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  task automatic t_reset();
    rd_chk("sel rst", `E1NB_IDX_SEL, 8'h00);
    rd_chk("cwd rst", `E1NB_IDX_CWD, 8'h0f);
    wr(`E1NB_IDX_CWD, 8'hf0);
    rd_chk("cwd held", `E1NB_IDX_CWD, 8'h0f);
    rd_chk("unmapped", 10'h3ff, 8'h00);
    wr(`E1NB_IDX_CTRL, 8'h01);
    avs_byteenable <= 4'h0;
    wr(`E1NB_IDX_SEL, 8'he0);
    avs_byteenable <= 4'hf;
    rd_chk("sel no be", `E1NB_IDX_SEL, 8'h00);
  endtask : t_reset

  // Second codeword is written mid first submultiframe: must wait
  task automatic t_codeword();
    for (int s = 3; s < 8; s++)
    begin
      sel = 3'(s);
      cw_act = 8'ha5;
      wr(`E1NB_IDX_SEL, {sel, 5'h0});
      wr(`E1NB_IDX_CWD, cw_act);
      rd_chk("sel", `E1NB_IDX_SEL, {sel, 5'h0});
      frames(0, 3);
      wr(`E1NB_IDX_CWD, 8'h5a);
      frames(4, 7);
      cw_act = 8'h5a;
      frames(8, 15);
      drain();
      rd_chk("smf", `E1NB_IDX_STAT, 8'h01);
    end
  endtask : t_codeword

  task automatic t_fifo();
    int n;
    hold <= 1'b1;
    up_valid <= 1'b1;
    up_ts0 <= 1'b0;
    up_bit_pos <= 3'h0;
    for (n = 0; n < 12; n++)
    begin
      {up_frame, up_data} <= {4'(n), n[0]};
      @(posedge sys_clk);
      if (up_ready !== 1'b1)
        break;
      exp_q.push_back({4'h0, 4'(n), n[0], 1'b0});
    end
    up_valid <= 1'b0;
    check("fill", n >= 8 && n < 12, 1'b1);
    hold <= 1'b0;
    drain();
  endtask : t_fifo

  task automatic t_pass();
    cw_act = 8'hff;
    wr(`E1NB_IDX_CWD, 8'hff);
    for (int s = 0; s < 4; s++)
    begin
      sel = (s == 3) ? 3'h4 : 3'(s);
      dis = (s == 3);
      wr(`E1NB_IDX_CTRL, {6'h0, dis, 1'b1});
      wr(`E1NB_IDX_SEL, {sel, 5'h0});
      frames(0, 15);
      drain();
    end
    wr(`E1NB_IDX_CTRL, 8'h00);
    rd_chk("sel t1", `E1NB_IDX_SEL, 8'h00);
    rd_chk("cwd t1", `E1NB_IDX_CWD, 8'h0f);
  endtask : t_pass

  initial
  begin
    repeat (12)
      @(posedge sys_clk);
    reset_n <= 1'b1;
    t_reset();
    t_codeword();
    t_fifo();
    t_pass();
    final_report();
  end
endmodule : e1nb_inserter_tb

// file: tb/e1nb_line_rx.sv
// Far end line receiver model: accepts output words with stalls
`timescale 1ns/1ps
module e1nb_line_rx
(
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic reset_n,
  // Stream from the inserter
  input  wire logic hold,
  output logic      dn_ready
);
  logic [1:0] stall_r;

  // Refuses one cycle in four so stalls land at every pipeline phase
  always_ff @(posedge sys_clk or negedge reset_n)
    if (!reset_n)
      stall_r <= 2'h0;
    else
      stall_r <= stall_r + 2'h1;
  assign dn_ready = !hold && stall_r != 2'h3;
endmodule : e1nb_line_rx

// file: tb/e1nb_props.sv
// Port checker of the national bit inserter
`timescale 1ns/1ps
`include "e1nb_regs.svh"
module e1nb_props
(
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        reset_n,
  // Register bus
  input wire logic [11:0] avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // Output stream
  input wire logic        dn_valid,
  input wire logic        dn_ready,
  input wire logic        dn_data,
  input wire logic        dn_ts0,
  input wire logic [2:0]  dn_bit_pos,
  input wire logic [3:0]  dn_frame,
  input wire logic        dn_inserted
);
  logic       e1_r;
  logic       dis_r;
  logic [2:0] sel_r;
  wire        wr_take = avs_write && !avs_waitrequest && avs_byteenable[0];
  wire        rd_t1 = avs_read && !avs_waitrequest && !e1_r;

  // --------------------------------------------------------------------
  // Settings shadow; valid because the stream is idle when they change
  // --------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n)
    if (!reset_n)
    begin
      e1_r  <= 1'b0;
      dis_r <= 1'b0;
      sel_r <= 3'h0;
    end
    else if (wr_take && avs_address == {`E1NB_IDX_CTRL, 2'b00})
    begin
      e1_r  <= avs_writedata[0];
      dis_r <= avs_writedata[1];
      sel_r <= avs_writedata[0] ? sel_r : 3'h0;
    end
    else if (wr_take && avs_address == {`E1NB_IDX_SEL, 2'b00} && e1_r)
      sel_r <= avs_writedata[7:5];

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  chk_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  chk_answer_next: assert property ($rose(avs_read || avs_write)
    |=> !avs_waitrequest) else $error("bus answer late");
  chk_dn_hold: assert property (dn_valid && !dn_ready |=> dn_valid &&
    $stable({dn_data, dn_ts0, dn_bit_pos, dn_frame, dn_inserted}))
    else $error("stalled word changed");
  chk_ins_pos: assert property (dn_valid && dn_inserted |->
    dn_bit_pos == sel_r && sel_r >= 3'h3) else $error("bad insert bit");
  chk_ins_frame: assert property (dn_valid && dn_inserted |->
    dn_ts0 && dn_frame[0]) else $error("bad insert frame");
  chk_ins_off: assert property (dn_valid && dis_r |->
    !dn_inserted) else $error("insert while disabled");
  chk_undef_pass: assert property (dn_valid && sel_r < 3'h3 |->
    !dn_inserted) else $error("insert on undefined code");
  chk_t1_sel: assert property (rd_t1 &&
    avs_address == {`E1NB_IDX_SEL, 2'b00} |-> avs_readdata[7:0] == 8'h00)
    else $error("select not held");
  chk_t1_cwd: assert property (rd_t1 &&
    avs_address == {`E1NB_IDX_CWD, 2'b00} |-> avs_readdata[7:0] == 8'h0f)
    else $error("codeword not held");
endmodule : e1nb_props

bind e1nb_inserter e1nb_props i_e1nb_props (.*);
